// ===== core/xfer_exec.sv
// execution of the conditional jump and data transfer instruction groups
//
// Summary of operation
// - carry jumps go to pc plus offset plus one; clear/same-or-higher on C=0, lower on C=1.
// - carry-clear jump behaves exactly like same-or-higher and changes no flag.
// - signed jumps test N xor V: greater-equal on zero, less-than on one.
// - half-carry jumps: one on H set, other on H clear, same target.
// - transfer-bit jumps: one on T equal one, other on T zero, no flags.
// - overflow jumps: one on V set, other on V clear, same relative target.
// - interrupt jumps: one on I one, other on I zero, I untouched.
// - byte copy, pair copy and constant load finish in one cycle, no flags.
// - pointer load reads byte at pointer; post-increment form bumps pointer; two cycles.
// - pre-decrement load lowers pointer first, reads new address, two cycles.
// - offset load reads pointer plus displacement, pointer kept, only second/third pairs.
// - absolute load reads byte at instruction address into register, two cycles.
// - pointer store writes register at pointer; post-increment bumps pointer; two cycles.
// - pre-decrement store lowers pointer then writes there, two cycles.
// - offset store writes at pointer plus displacement, pointer kept, two cycles.
`timescale 1ns/10ps
module xfer_exec #(
  parameter int PC_W = exec_pkg::PC_W_DEF
) (
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_nrst,
  input  wire logic                              i_op_valid,
  input  wire exec_pkg::op_e                     i_op,
  input  wire exec_pkg::cond_e                   i_cond,
  input  wire logic [exec_pkg::REG_AW-1:0]       i_rd,
  input  wire logic [exec_pkg::REG_AW-1:0]       i_rr,
  input  wire logic [exec_pkg::REG_DW-1:0]       i_imm,
  input  wire exec_pkg::ptr_sel_e                i_ptr_sel,
  input  wire exec_pkg::ptr_mode_e               i_ptr_mode,
  input  wire logic [exec_pkg::DISP_W-1:0]       i_disp,
  input  wire logic [exec_pkg::PTR_W-1:0]        i_addr,
  input  wire logic [exec_pkg::OFS_W-1:0]        i_offset,
  input  wire logic [exec_pkg::REG_DW-1:0]       i_sreg,
  input  wire logic [exec_pkg::REG_DW-1:0]       i_dm_rdata,
  output logic                                   o_op_ready,
  output logic                                   o_refused,
  output logic [PC_W-1:0]                        o_pc,
  output logic [exec_pkg::PTR_W-1:0]             o_dm_addr,
  output logic                                   o_dm_re,
  output logic                                   o_dm_we,
  output logic [exec_pkg::REG_DW-1:0]            o_dm_wdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_bubble,
    st_one,
    st_ld_wait,
    st_ld_done,
    st_st_data
  } exec_state_e;

  typedef struct packed {
    exec_state_e                              st;
    logic                                     ready;
    logic                                     refused;
    logic [PC_W-1:0]                          pc;
    exec_pkg::op_e                            op;
    logic [exec_pkg::REG_AW-1:0]              rd;
    logic [exec_pkg::REG_DW-1:0]              imm;
    logic [2:0][exec_pkg::PTR_W-1:0]          ptr;
    logic [exec_pkg::PTR_W-1:0]               dm_addr;
    logic                                     dm_re;
    logic                                     dm_we;
    logic [exec_pkg::REG_DW-1:0]              dm_wdata;
  } exec_s;

  exec_s exec_reg;
  exec_s exec_next;

  rf_if rf ();
  logic take;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // low register number of a pointer pair
  function automatic logic [exec_pkg::REG_AW-1:0] ptr_lo(input exec_pkg::ptr_sel_e sel);
    case (sel)
      exec_pkg::ptr_x: ptr_lo = exec_pkg::PTR_X_LO;
      exec_pkg::ptr_y: ptr_lo = exec_pkg::PTR_Y_LO;
      default:         ptr_lo = exec_pkg::PTR_Z_LO;
    endcase
  endfunction

  // keeps the pointer copies in step with any byte written to r26..r31
  function automatic logic [2:0][exec_pkg::PTR_W-1:0] track_ptr(
    input logic [2:0][exec_pkg::PTR_W-1:0] cur,
    input logic                            we,
    input logic [exec_pkg::REG_AW-1:0]     wa,
    input logic [exec_pkg::REG_DW-1:0]     wd
  );
    logic [2:0][exec_pkg::PTR_W-1:0] res;
    res = cur;
    if (we && wa >= exec_pkg::PTR_X_LO) begin
      if (wa[0]) begin
        res[2'((wa - exec_pkg::PTR_X_LO) >> 1)][15:8] = wd;
      end else begin
        res[2'((wa - exec_pkg::PTR_X_LO) >> 1)][7:0] = wd;
      end
    end
    track_ptr = res;
  endfunction

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  reg_bank #(
    .DEPTH (exec_pkg::REG_NUM)
  ) u_bank (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .rf        (rf.bank)
  );

  jump_cond u_cond (
    .i_sreg_bit_c (i_sreg[exec_pkg::FLAG_C]),
    .i_sreg       (i_sreg),
    .i_cond       (i_cond),
    .o_take       (take)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // the finishing work of the current instruction is applied first so
  // that an instruction accepted in the same cycle sees its pointer result
  always_comb begin
    logic [exec_pkg::PTR_W-1:0]    base;
    logic [exec_pkg::PTR_W-1:0]    eff;
    logic [exec_pkg::PTR_W-1:0]    upd;
    logic [exec_pkg::REG_AW-1:0]   lo;
    logic                          is_ofs;
    logic                          is_load;
    base   = '0;
    eff    = '0;
    upd    = '0;
    lo     = '0;
    is_ofs = 1'b0;
    is_load = 1'b0;
    exec_next          = exec_reg;
    exec_next.dm_re    = 1'b0;
    exec_next.dm_we    = 1'b0;
    exec_next.refused  = 1'b0;
    rf.rd_addr_a       = i_rr;
    rf.rd_addr_b       = {i_rr[exec_pkg::REG_AW-1:1], 1'b1};
    rf.we              = '0;
    rf.wa              = '0;
    rf.wd              = '0;

    case (exec_reg.st)
      st_idle: begin
        exec_next.ready = 1'b1;
      end
      st_bubble: begin
        exec_next.st    = st_idle;
        exec_next.ready = 1'b1;
      end
      st_one: begin
        rf.we[0] = 1'b1;
        rf.wa[0] = exec_reg.rd;
        case (exec_reg.op)
          exec_pkg::copy_register_byte: begin
            rf.wd[0] = rf.rd_data_a;
          end
          exec_pkg::copy_register_pair: begin
            rf.wd[0] = rf.rd_data_a;
            rf.we[1] = 1'b1;
            rf.wa[1] = {exec_reg.rd[exec_pkg::REG_AW-1:1], 1'b1};
            rf.wd[1] = rf.rd_data_b;
          end
          default: begin
            rf.wd[0] = exec_reg.imm;
          end
        endcase
        exec_next.st = st_idle;
      end
      st_ld_wait: begin
        exec_next.st    = st_ld_done;
        exec_next.ready = 1'b1;
      end
      st_ld_done: begin
        rf.we[0]     = 1'b1;
        rf.wa[0]     = exec_reg.rd;
        rf.wd[0]     = i_dm_rdata;
        exec_next.st = st_idle;
      end
      st_st_data: begin
        // the source byte was read from the bank at acceptance
        exec_next.dm_we    = 1'b1;
        exec_next.dm_wdata = rf.rd_data_a;
        exec_next.ready    = 1'b1;
        exec_next.st       = st_idle;
      end
      default: begin
        exec_next.st    = st_idle;
        exec_next.ready = 1'b1;
      end
    endcase

    for (int l = 0; l < 2; l++) begin
      exec_next.ptr = track_ptr(exec_next.ptr, rf.we[l], rf.wa[l], rf.wd[l]);
    end

    if (exec_reg.ready && i_op_valid) begin
      exec_next.op  = i_op;
      exec_next.rd  = i_rd;
      exec_next.imm = i_imm;
      exec_next.pc  = exec_reg.pc + PC_W'(exec_pkg::PC_STEP1);
      exec_next.st  = st_idle;
      case (i_op)
        exec_pkg::op_jump: begin
          if (take) begin
            // two cycles: the target is out now, one dead cycle follows
            exec_next.pc    = exec_reg.pc + PC_W'(exec_pkg::PC_STEP1)
                            + {{(PC_W - exec_pkg::OFS_W){i_offset[exec_pkg::OFS_W-1]}}, i_offset};
            exec_next.st    = st_bubble;
            exec_next.ready = 1'b0;
          end else begin
            exec_next.ready = 1'b1;
          end
        end
        exec_pkg::copy_register_byte,
        exec_pkg::copy_register_pair,
        exec_pkg::load_constant: begin
          exec_next.st    = st_one;
          exec_next.ready = 1'b1;
        end
        exec_pkg::read_via_pointer,
        exec_pkg::read_pointer_offset,
        exec_pkg::write_via_pointer,
        exec_pkg::write_pointer_offset: begin
          is_ofs  = (i_op == exec_pkg::read_pointer_offset) || (i_op == exec_pkg::write_pointer_offset);
          is_load = (i_op == exec_pkg::read_via_pointer) || (i_op == exec_pkg::read_pointer_offset);
          if (is_ofs && i_ptr_sel == exec_pkg::ptr_x) begin
            // no displacement form on the first pair: dropped, pc still moves
            exec_next.refused = 1'b1;
            exec_next.ready   = 1'b1;
          end else begin
            base = exec_next.ptr[i_ptr_sel];
            lo   = ptr_lo(i_ptr_sel);
            if (is_ofs) begin
              eff = base + exec_pkg::PTR_W'(i_disp);
              upd = base;
            end else if (i_ptr_mode == exec_pkg::mode_pre_dec) begin
              eff = base - exec_pkg::PTR_STEP;
              upd = eff;
            end else if (i_ptr_mode == exec_pkg::mode_post_inc) begin
              eff = base;
              upd = base + exec_pkg::PTR_STEP;
            end else begin
              eff = base;
              upd = base;
            end
            if (upd != base) begin
              rf.we[2] = 1'b1;
              rf.wa[2] = lo;
              rf.wd[2] = upd[7:0];
              rf.we[3] = 1'b1;
              rf.wa[3] = {lo[exec_pkg::REG_AW-1:1], 1'b1};
              rf.wd[3] = upd[15:8];
              exec_next.ptr[i_ptr_sel] = upd;
            end
            exec_next.dm_addr = eff;
            exec_next.ready   = 1'b0;
            if (is_load) begin
              exec_next.dm_re = 1'b1;
              exec_next.st    = st_ld_wait;
            end else begin
              exec_next.st    = st_st_data;
            end
          end
        end
        exec_pkg::read_absolute_address: begin
          exec_next.pc      = exec_reg.pc + PC_W'(exec_pkg::PC_STEP2);
          exec_next.dm_addr = i_addr;
          exec_next.dm_re   = 1'b1;
          exec_next.st      = st_ld_wait;
          exec_next.ready   = 1'b0;
        end
        default: begin
          exec_next.ready = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      exec_reg          <= '0;
      exec_reg.st       <= st_idle;
      exec_reg.ready    <= 1'b1;
      exec_reg.op       <= exec_pkg::op_none;
      exec_reg.ptr      <= {3{exec_pkg::PTR_RST}};
      exec_reg.dm_wdata <= exec_pkg::REG_RST;
    end else begin
      exec_reg <= exec_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_op_ready = exec_reg.ready;
  assign o_refused  = exec_reg.refused;
  assign o_pc       = exec_reg.pc;
  assign o_dm_addr  = exec_reg.dm_addr;
  assign o_dm_re    = exec_reg.dm_re;
  assign o_dm_we    = exec_reg.dm_we;
  assign o_dm_wdata = exec_reg.dm_wdata;

endmodule

// ===== include/exec_pkg.sv
// constants, enumerations and field layouts shared by the transfer and jump execution block
package exec_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int REG_AW   = 5;
  localparam int REG_DW   = 8;
  localparam int REG_NUM  = 32;
  localparam int PTR_W    = 16;
  localparam int OFS_W    = 7;
  localparam int DISP_W   = 6;
  localparam int PC_W_DEF = 16;
  localparam int LANES    = 4;

  // ----------------------------------------------------------------
  // status flag bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ----------------------------------------------------------------
  // pointer pair low-byte register numbers, reset values, steps
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] PTR_X_LO  = 5'h1A;
  localparam logic [REG_AW-1:0] PTR_Y_LO  = 5'h1C;
  localparam logic [REG_AW-1:0] PTR_Z_LO  = 5'h1E;
  localparam logic [PTR_W-1:0]  PTR_RST   = 16'h0000;
  localparam logic [PTR_W-1:0]  PTR_STEP  = 16'h0001;
  localparam logic [REG_DW-1:0] REG_RST   = 8'h00;
  localparam int                PC_STEP1  = 1;
  localparam int                PC_STEP2  = 2;

  // ----------------------------------------------------------------
  // decoded operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    op_none,
    op_jump,
    copy_register_byte,
    copy_register_pair,
    load_constant,
    read_via_pointer,
    read_pointer_offset,
    read_absolute_address,
    write_via_pointer,
    write_pointer_offset
  } op_e;

  typedef enum logic [3:0] {
    jump_carry_clear,
    jump_same_or_higher,
    jump_lower_unsigned,
    jump_negative,
    jump_positive,
    jump_signed_greater_equal,
    jump_signed_less,
    jump_half_carry_set,
    jump_half_carry_clear,
    jump_transfer_bit_set,
    jump_transfer_bit_clear,
    jump_overflow_set,
    jump_overflow_clear,
    jump_irq_enabled,
    jump_irq_disabled
  } cond_e;

  typedef enum logic [1:0] {
    ptr_x,
    ptr_y,
    ptr_z
  } ptr_sel_e;

  typedef enum logic [1:0] {
    mode_plain,
    mode_post_inc,
    mode_pre_dec
  } ptr_mode_e;

endpackage

// ===== include/rf_if.sv
// register bank access bundle between the execution core and its register storage
`timescale 1ns/10ps
interface rf_if;
  logic [exec_pkg::REG_AW-1:0]                    rd_addr_a;
  logic [exec_pkg::REG_AW-1:0]                    rd_addr_b;
  logic [exec_pkg::REG_DW-1:0]                    rd_data_a;
  logic [exec_pkg::REG_DW-1:0]                    rd_data_b;
  logic [exec_pkg::LANES-1:0]                     we;
  logic [exec_pkg::LANES-1:0][exec_pkg::REG_AW-1:0] wa;
  logic [exec_pkg::LANES-1:0][exec_pkg::REG_DW-1:0] wd;

  modport bank (input rd_addr_a, rd_addr_b, we, wa, wd, output rd_data_a, rd_data_b);
  modport core (output rd_addr_a, rd_addr_b, we, wa, wd, input rd_data_a, rd_data_b);
endinterface

// ===== core/reg_bank.sv
// working register storage: multi-lane write, two registered read ports with write-through
`timescale 1ns/10ps
module reg_bank #(
  parameter int DEPTH = exec_pkg::REG_NUM
) (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  rf_if.bank        rf
);

  typedef struct packed {
    logic [DEPTH-1:0][exec_pkg::REG_DW-1:0] mem;
    logic [exec_pkg::REG_DW-1:0]            rd_a;
    logic [exec_pkg::REG_DW-1:0]            rd_b;
  } bank_s;

  bank_s bank_reg;
  bank_s bank_next;

  // ----------------------------------------------------------------
  // write lanes, then reads
  // ----------------------------------------------------------------
  // higher lanes win on a clash; reads see this edge's writes so the
  // core needs no forwarding path of its own
  always_comb begin
    bank_next = bank_reg;
    for (int l = 0; l < exec_pkg::LANES; l++) begin
      if (rf.we[l]) begin
        bank_next.mem[rf.wa[l]] = rf.wd[l];
      end
    end
    bank_next.rd_a = bank_next.mem[rf.rd_addr_a];
    bank_next.rd_b = bank_next.mem[rf.rd_addr_b];
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bank_reg <= '0;
    end else begin
      bank_reg <= bank_next;
    end
  end

  assign rf.rd_data_a = bank_reg.rd_a;
  assign rf.rd_data_b = bank_reg.rd_b;

endmodule

// ===== core/jump_cond.sv
// status flag test for the conditional relative jumps
`timescale 1ns/10ps
module jump_cond (
  input  wire logic                            i_sreg_bit_c,
  input  wire logic [exec_pkg::REG_DW-1:0]     i_sreg,
  input  wire exec_pkg::cond_e                 i_cond,
  output logic                                 o_take
);

  // ----------------------------------------------------------------
  // condition select
  // ----------------------------------------------------------------
  always_comb begin
    case (i_cond)
      exec_pkg::jump_carry_clear:          o_take = ~i_sreg_bit_c;
      exec_pkg::jump_same_or_higher:       o_take = ~i_sreg_bit_c;
      exec_pkg::jump_lower_unsigned:       o_take = i_sreg_bit_c;
      exec_pkg::jump_negative:             o_take = i_sreg[exec_pkg::FLAG_N];
      exec_pkg::jump_positive:             o_take = ~i_sreg[exec_pkg::FLAG_N];
      exec_pkg::jump_signed_greater_equal: o_take = ~(i_sreg[exec_pkg::FLAG_N] ^ i_sreg[exec_pkg::FLAG_V]);
      exec_pkg::jump_signed_less:          o_take = i_sreg[exec_pkg::FLAG_N] ^ i_sreg[exec_pkg::FLAG_V];
      exec_pkg::jump_half_carry_set:       o_take = i_sreg[exec_pkg::FLAG_H];
      exec_pkg::jump_half_carry_clear:     o_take = ~i_sreg[exec_pkg::FLAG_H];
      exec_pkg::jump_transfer_bit_set:     o_take = i_sreg[exec_pkg::FLAG_T];
      exec_pkg::jump_transfer_bit_clear:   o_take = ~i_sreg[exec_pkg::FLAG_T];
      exec_pkg::jump_overflow_set:         o_take = i_sreg[exec_pkg::FLAG_V];
      exec_pkg::jump_overflow_clear:       o_take = ~i_sreg[exec_pkg::FLAG_V];
      exec_pkg::jump_irq_enabled:          o_take = i_sreg[exec_pkg::FLAG_I];
      exec_pkg::jump_irq_disabled:         o_take = ~i_sreg[exec_pkg::FLAG_I];
      default:                             o_take = 1'b0;
    endcase
  end

endmodule

// ===== test/data_mem_model.sv
// data memory model for the execution block
`timescale 1ns/10ps
module data_mem_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_re,
  input  wire logic        i_we,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata
);
  logic [7:0] mem [256];
  initial begin
    for (int a = 0; a < 256; a++) mem[a] = 8'(a) ^ 8'hA5;
    o_rdata = 8'h00;
  end
  // outside the answer cycle the bus toggles, so a sample one cycle late reads the inverted byte
  always @(posedge i_sys_clk) begin
    o_rdata <= i_re ? mem[i_addr[7:0]] : ~o_rdata;
    if (i_we) mem[i_addr[7:0]] <= i_wdata;
  end
endmodule

// ===== test/xfer_exec_chk.sv
// assertions on the execution block ports
`timescale 1ns/10ps
module xfer_exec_chk #(parameter int PC_W = 16) (
  input wire logic            i_sys_clk,
  input wire logic            i_nrst,
  input wire logic            i_op_valid,
  input wire exec_pkg::op_e   i_op,
  input wire exec_pkg::ptr_sel_e i_ptr_sel,
  input wire logic [15:0]     i_addr,
  input wire logic [6:0]      i_offset,
  input wire logic            o_op_ready,
  input wire logic            o_refused,
  input wire logic [PC_W-1:0] o_pc,
  input wire logic [15:0]     o_dm_addr,
  input wire logic            o_dm_re,
  input wire logic            o_dm_we
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  logic acc, xo, rd_ok, wr_ok;
  logic [PC_W-1:0] tgt;
  assign acc = i_op_valid && o_op_ready;
  assign xo = i_ptr_sel == exec_pkg::ptr_x;
  assign rd_ok = acc && (i_op == exec_pkg::read_via_pointer || i_op == exec_pkg::read_absolute_address
    || i_op == exec_pkg::read_pointer_offset && !xo);
  assign wr_ok = acc && (i_op == exec_pkg::write_via_pointer || i_op == exec_pkg::write_pointer_offset && !xo);
  assign tgt = o_pc + PC_W'(1) + PC_W'(signed'(i_offset));
  chk_jump_timing: assert property (acc && i_op == exec_pkg::op_jump |=>
    (o_op_ready && o_pc == $past(o_pc) + PC_W'(1)) or (!o_op_ready && o_pc == $past(tgt) ##1 o_op_ready))
    else $error("jump target or timing wrong");
  chk_one_cycle: assert property (acc && (i_op == exec_pkg::copy_register_byte
    || i_op == exec_pkg::copy_register_pair || i_op == exec_pkg::load_constant)
    |=> o_op_ready && !o_dm_re && !o_dm_we && o_pc == $past(o_pc) + PC_W'(1)) else $error("copy not one cycle");
  chk_load_strobe: assert property (rd_ok |=> o_dm_re && !o_op_ready ##1 !o_dm_re && o_op_ready)
    else $error("load strobe or timing wrong");
  chk_abs_addr: assert property (acc && i_op == exec_pkg::read_absolute_address |=>
    o_dm_addr == $past(i_addr) && o_pc == $past(o_pc) + PC_W'(2)) else $error("absolute load wrong");
  chk_store_strobe: assert property (wr_ok |=> !o_dm_we && !o_op_ready ##1
    o_dm_we && o_op_ready && $stable(o_dm_addr)) else $error("store strobe or timing wrong");
  chk_refuse_x: assert property (acc && xo && (i_op == exec_pkg::read_pointer_offset
    || i_op == exec_pkg::write_pointer_offset) |=> o_refused && o_op_ready && !o_dm_re ##1 !o_refused && !o_dm_we)
    else $error("offset form on first pair not refused");
  chk_read_pulse: assert property (o_dm_re |=> !o_dm_re) else $error("read strobe too long");
  chk_ready_gap: assert property (!o_op_ready |=> o_op_ready) else $error("busy too long");
endmodule
bind xfer_exec xfer_exec_chk #(.PC_W(PC_W)) xfer_exec_chk_i (.i_sys_clk, .i_nrst, .i_op_valid, .i_op,
  .i_ptr_sel, .i_addr, .i_offset, .o_op_ready, .o_refused, .o_pc, .o_dm_addr, .o_dm_re, .o_dm_we);

// ===== test/xfer_exec_tb.sv
// self-checking bench for the transfer and jump execution block
`timescale 1ns/10ps
module xfer_exec_tb;
  logic i_sys_clk = 0, i_nrst = 0, i_op_valid = 0, o_op_ready, o_refused, o_dm_re, o_dm_we, tk;
  exec_pkg::op_e i_op = exec_pkg::op_none;
  exec_pkg::cond_e i_cond = exec_pkg::jump_carry_clear;
  exec_pkg::ptr_sel_e i_ptr_sel = exec_pkg::ptr_x;
  exec_pkg::ptr_mode_e i_ptr_mode = exec_pkg::mode_plain;
  logic [4:0] i_rd = 0, i_rr = 0;
  logic [7:0] i_imm = 0, i_sreg = 0, i_dm_rdata, o_dm_wdata, sr;
  logic [5:0] i_disp = 0;
  logic [6:0] i_offset = 0;
  logic [15:0] i_addr = 0, o_pc, o_dm_addr, exp_pc = 0, ofs, stp;
  int err_count = 0, checks_done = 0;
  // bit c is the flag level that makes condition c jump
  localparam logic [14:0] JUMP_WHEN = 15'h2ACC;
  xfer_exec xfer_exec_i (.i_sys_clk, .i_nrst, .i_op_valid, .i_op, .i_cond, .i_rd, .i_rr, .i_imm, .i_ptr_sel,
    .i_ptr_mode, .i_disp, .i_addr, .i_offset, .i_sreg, .i_dm_rdata, .o_op_ready, .o_refused, .o_pc, .o_dm_addr,
    .o_dm_re, .o_dm_we, .o_dm_wdata);
  data_mem_model data_mem_model_i (.i_sys_clk, .i_re(o_dm_re), .i_we(o_dm_we), .i_addr(o_dm_addr),
    .i_wdata(o_dm_wdata), .o_rdata(i_dm_rdata));
  initial forever #4 i_sys_clk = ~i_sys_clk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // v carries the constant, address, displacement or jump offset; step and lat are pc advance and busy cycles
  task automatic issue(input exec_pkg::op_e op, input exec_pkg::ptr_sel_e ps, input exec_pkg::ptr_mode_e pm,
    input logic [4:0] rd, input logic [4:0] rr, input logic [15:0] v, input logic [15:0] step, input int lat);
    int low;
    low = 0;
    @(posedge i_sys_clk);
    i_op <= op;
    i_ptr_sel <= ps;
    i_ptr_mode <= pm;
    i_rd <= rd;
    i_rr <= rr;
    i_imm <= v[7:0];
    i_addr <= v;
    i_disp <= v[5:0];
    i_offset <= v[6:0];
    i_op_valid <= 1'b1;
    @(negedge i_sys_clk);
    while (o_op_ready !== 1'b1) @(negedge i_sys_clk);
    @(posedge i_sys_clk);
    i_op_valid <= 1'b0;
    exp_pc = exp_pc + step;
    @(negedge i_sys_clk);
    while (o_op_ready !== 1'b1) begin
      low++;
      @(negedge i_sys_clk);
    end
    cmp(o_pc, exp_pc);
    cmp(16'(low), 16'(lat));
  endtask
  task automatic store(input exec_pkg::ptr_sel_e ps, input exec_pkg::ptr_mode_e pm, input logic [4:0] rr,
    input logic [15:0] v, input logic [15:0] ea, input logic [7:0] ed);
    issue(v == 0 ? exec_pkg::write_via_pointer : exec_pkg::write_pointer_offset, ps, pm, 0, rr, v, 1, 1);
    cmp({15'h0000, o_dm_we}, 16'h0001);
    cmp(o_dm_addr, ea);
    cmp({8'h00, o_dm_wdata}, {8'h00, ed});
  endtask
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    err_count++;
    results();
  end
  initial begin
    static logic [12:0] cst [9] = '{{5'h1C, 8'h10}, {5'h1D, 8'h00}, {5'h1E, 8'h20}, {5'h1F, 8'h00}, {5'h1A, 8'h30},
      {5'h1B, 8'h00}, {5'h01, 8'h5A}, {5'h04, 8'h11}, {5'h05, 8'h22}};
    static int fb [15] = '{0, 0, 0, 2, 2, 9, 9, 5, 5, 6, 6, 3, 3, 7, 7};
    repeat (10) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    @(negedge i_sys_clk);
    cmp(o_pc, 16'h0000);
    foreach (cst[k]) issue(exec_pkg::load_constant, exec_pkg::ptr_x, exec_pkg::mode_plain, cst[k][12:8], 0,
      {8'h00, cst[k][7:0]}, 1, 0);
    store(exec_pkg::ptr_y, exec_pkg::mode_post_inc, 1, 0, 16'h0010, 8'h5A);
    store(exec_pkg::ptr_y, exec_pkg::mode_pre_dec, 1, 0, 16'h0010, 8'h5A);
    store(exec_pkg::ptr_y, exec_pkg::mode_plain, 1, 16'h003F, 16'h004F, 8'h5A);
    store(exec_pkg::ptr_y, exec_pkg::mode_plain, 1, 0, 16'h0010, 8'h5A);
    issue(exec_pkg::copy_register_byte, exec_pkg::ptr_x, exec_pkg::mode_plain, 2, 1, 0, 1, 0);
    store(exec_pkg::ptr_x, exec_pkg::mode_plain, 2, 0, 16'h0030, 8'h5A);
    issue(exec_pkg::read_via_pointer, exec_pkg::ptr_z, exec_pkg::mode_post_inc, 6, 0, 0, 1, 1);
    store(exec_pkg::ptr_y, exec_pkg::mode_plain, 6, 0, 16'h0010, 8'h85);
    issue(exec_pkg::read_via_pointer, exec_pkg::ptr_z, exec_pkg::mode_pre_dec, 7, 0, 0, 1, 1);
    store(exec_pkg::ptr_z, exec_pkg::mode_plain, 7, 0, 16'h0020, 8'h85);
    issue(exec_pkg::read_pointer_offset, exec_pkg::ptr_y, exec_pkg::mode_plain, 8, 0, 5, 1, 1);
    store(exec_pkg::ptr_y, exec_pkg::mode_plain, 8, 0, 16'h0010, 8'hB0);
    issue(exec_pkg::read_absolute_address, exec_pkg::ptr_x, exec_pkg::mode_plain, 9, 0, 16'h0042, 2, 1);
    store(exec_pkg::ptr_y, exec_pkg::mode_plain, 9, 0, 16'h0010, 8'hE7);
    issue(exec_pkg::copy_register_pair, exec_pkg::ptr_x, exec_pkg::mode_plain, 26, 4, 0, 1, 0);
    store(exec_pkg::ptr_x, exec_pkg::mode_plain, 5, 0, 16'h2211, 8'h22);
    issue(exec_pkg::read_pointer_offset, exec_pkg::ptr_x, exec_pkg::mode_plain, 10, 0, 1, 1, 0);
    cmp({15'h0000, o_refused}, 16'h0001);
    // three flag patterns give every condition both outcomes, the signed pair included
    for (int c = 0; c < 15; c++) begin
      for (int p = 0; p < 3; p++) begin
        sr = p == 0 ? 8'h00 : p == 1 ? 8'hFF : 8'h08;
        ofs = p == 1 ? 16'hFFFD : 16'h0005;
        tk = (fb[c] == 9 ? sr[2] ^ sr[3] : sr[fb[c]]) == JUMP_WHEN[c];
        stp = tk ? 16'h0001 + ofs : 16'h0001;
        @(posedge i_sys_clk);
        i_cond <= exec_pkg::cond_e'(c);
        i_sreg <= sr;
        issue(exec_pkg::op_jump, exec_pkg::ptr_x, exec_pkg::mode_plain,
          0, 0, ofs, stp, tk);
      end
    end
    results();
  end
endmodule
